// >>> src/rtcam_defines.svh
`ifndef RTCAM_DEFINES_SVH
`define RTCAM_DEFINES_SVH

// register offsets
`define RTCAM_OFF_SEC 4'h0
`define RTCAM_OFF_MIN 4'h1
`define RTCAM_OFF_HOUR 4'h2
`define RTCAM_OFF_WDAY 4'h3
`define RTCAM_OFF_MDAY 4'h4
`define RTCAM_OFF_A1_SEC 4'h7
`define RTCAM_OFF_A1_MIN 4'h8
`define RTCAM_OFF_A1_HOUR 4'h9
`define RTCAM_OFF_A1_DAY 4'ha
`define RTCAM_OFF_A2_MIN 4'hb
`define RTCAM_OFF_A2_HOUR 4'hc
`define RTCAM_OFF_A2_DAY 4'hd
`define RTCAM_OFF_CTRL 4'he
`define RTCAM_OFF_STAT 4'hf

// field positions
`define RTCAM_MASK_BIT 7
`define RTCAM_DAYSEL_BIT 6
`define RTCAM_FMT12_BIT 6
`define RTCAM_PM_BIT 5
`define RTCAM_CTRL_NOCOUNT_BIT 7
`define RTCAM_CTRL_MAP_BIT 2
`define RTCAM_CTRL_ALARM_TWO_IRQ_ENABLE_BIT 1
`define RTCAM_CTRL_ALARM_ONE_IRQ_ENABLE_BIT 0
`define RTCAM_STAT_OSF_BIT 7
`define RTCAM_STAT_A2F_BIT 1
`define RTCAM_STAT_A1F_BIT 0

// writable bits
`define RTCAM_WM_SEC 8'h7f
`define RTCAM_WM_WDAY 8'h07
`define RTCAM_WM_MDAY 8'h3f
`define RTCAM_WM_MONTH 8'h1f
`define RTCAM_WM_CTRL 8'h9f
`define RTCAM_WM_ALL 8'hff

// reset values
`define RTCAM_RST_ZERO 8'h00
`define RTCAM_RST_ONE 8'h01
`define RTCAM_RST_CTRL 8'h1c

// counting limits (bcd)
`define RTCAM_MAX_SEC 7'h59
`define RTCAM_MAX_H24 6'h23
`define RTCAM_H12_ELEVEN 5'h11
`define RTCAM_H12_TWELVE 5'h12
`define RTCAM_MAX_WDAY 3'h7
`define RTCAM_MAX_MDAY 6'h31

// bus address
`define RTCAM_SLAVE_ADDR 7'h68
`define RTCAM_BITS_PER_BYTE 4'h8

`endif

// >>> src/rtcam_pkg.sv
package rtcam_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_RX_ACK = 3'b100,
        ST_TX = 3'b101,
        ST_TX_ACK = 3'b110
    } rtcam_state_type;

    typedef struct packed {
        logic en;
        logic [3:0] addr;
        logic [7:0] data;
    } rtcam_wr_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } rtcam_lines_type;

endpackage : rtcam_pkg

// >>> src/rtcam_alarm_core.sv
`timescale 1ns/1ps
`include "rtcam_defines.svh"
// Overview of operation
// - two alarms, shared or separate interrupt pins
// - bit 7 of alarm registers masks field
// - unmasked alarm matches time offsets 00h-04h
// - day/date bit 6 selects weekday or date
// - match sets alarm flag in status
// - flag and enable drive assigned interrupt
// - compare only at once-per-second update
// - alarm one mask bits select repeat rate
// - alarm one five rates; other masks ignored
// - alarm two all masked: each minute, :00
// - alarm two rates; other masks ignored
// - idle bus lines stay released high
// - start/stop: data edge while clock high
// - transmit changes data only with clock low
// - one data bit per clock pulse
// - answer only own slave address
// - all bus pins open-drain, pull low only
// - hour bit 6: 0 24-hour, 1 12-hour
// - slave address 1101000 plus read/write bit
// - weekday counts 1 to 7; fields bcd
module rtcam_alarm_core
    import rtcam_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // time base domain
    input wire logic time_clk,
    input wire logic time_rst_n,
    input wire logic time_tick,
    // serial bus pins
    input wire rtcam_lines_type bus_i,
    output logic sda_o,
    output logic sda_oe,
    // interrupt pins
    output logic irq_out_primary_o,
    output logic irq_out_primary_oe,
    output logic wave_or_irq_out_secondary_o,
    output logic wave_or_irq_out_secondary_oe
);

    // time base crossing: toggle in time base domain, three flops in core domain
    logic tick_tgl_ff;
    logic [2:0] tick_sync_ff;
    always_ff @(posedge time_clk) begin
        if (!time_rst_n) tick_tgl_ff <= 1'b0;
        else if (time_tick) tick_tgl_ff <= ~tick_tgl_ff;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) tick_sync_ff <= 3'h0;
        else tick_sync_ff <= {tick_sync_ff[1:0], tick_tgl_ff};
    end
    wire tick_core = tick_sync_ff[2] ^ tick_sync_ff[1];

    // bus pin synchronisers
    logic [1:0] scl_sync_ff, sda_sync_ff;
    logic scl_d_ff, sda_d_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], bus_i.scl};
            sda_sync_ff <= {sda_sync_ff[0], bus_i.sda};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
        end
    end
    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // register storage
    logic [7:0] regs_ff [0:15];
    logic [7:0] nxt_regs [0:15];
    logic alarm_one_flag_ff, alarm_two_flag_ff, osc_stopped_flag_ff;
    logic eval_ff;
    rtcam_wr_type wr;

    wire [7:0] ctrl = regs_ff[`RTCAM_OFF_CTRL];
    wire time_count_disable_n = ctrl[`RTCAM_CTRL_NOCOUNT_BIT];
    wire irq_mapping_select = ctrl[`RTCAM_CTRL_MAP_BIT];
    wire alarm_two_irq_enable = ctrl[`RTCAM_CTRL_ALARM_TWO_IRQ_ENABLE_BIT];
    wire alarm_one_irq_enable = ctrl[`RTCAM_CTRL_ALARM_ONE_IRQ_ENABLE_BIT];

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction

    function automatic logic [7:0] wr_mask(input logic [3:0] a);
        case (a)
            `RTCAM_OFF_SEC, `RTCAM_OFF_MIN, `RTCAM_OFF_HOUR: return `RTCAM_WM_SEC;
            `RTCAM_OFF_WDAY: return `RTCAM_WM_WDAY;
            `RTCAM_OFF_MDAY: return `RTCAM_WM_MDAY;
            4'h5: return `RTCAM_WM_MONTH;
            `RTCAM_OFF_CTRL: return `RTCAM_WM_CTRL;
            default: return `RTCAM_WM_ALL;
        endcase
    endfunction

    // once-per-second counting chain, bcd throughout
    wire count_upd = tick_core & ~time_count_disable_n;
    wire [7:0] t_sec = regs_ff[`RTCAM_OFF_SEC];
    wire [7:0] t_min = regs_ff[`RTCAM_OFF_MIN];
    wire [7:0] t_hour = regs_ff[`RTCAM_OFF_HOUR];
    wire [7:0] t_wday = regs_ff[`RTCAM_OFF_WDAY];
    wire [7:0] t_mday = regs_ff[`RTCAM_OFF_MDAY];
    wire sec_wrap = t_sec[6:0] == `RTCAM_MAX_SEC;
    wire min_wrap = sec_wrap & (t_min[6:0] == `RTCAM_MAX_SEC);
    wire hour_12 = t_hour[`RTCAM_FMT12_BIT];
    wire hour_pm = t_hour[`RTCAM_PM_BIT];
    wire day_wrap = min_wrap & (hour_12 ? (hour_pm & t_hour[4:0] == `RTCAM_H12_ELEVEN)
                                        : (t_hour[5:0] == `RTCAM_MAX_H24));
    logic [7:0] hour_next;
    always_comb begin
        if (!hour_12) hour_next = (t_hour[5:0] == `RTCAM_MAX_H24) ? 8'h00 : bcd_inc(t_hour);
        else if (t_hour[4:0] == `RTCAM_H12_TWELVE) hour_next = {t_hour[7:5], 5'h01};
        else if (t_hour[4:0] == `RTCAM_H12_ELEVEN) hour_next = {t_hour[7:6], ~hour_pm, 5'h12};
        else hour_next = bcd_inc(t_hour);
    end

    always_comb begin
        for (int i = 0; i < 16; i++) nxt_regs[i] = regs_ff[i];
        if (count_upd) begin
            nxt_regs[`RTCAM_OFF_SEC] = sec_wrap ? 8'h00 : bcd_inc(t_sec);
            if (sec_wrap) nxt_regs[`RTCAM_OFF_MIN] = min_wrap ? 8'h00 : bcd_inc(t_min);
            if (min_wrap) nxt_regs[`RTCAM_OFF_HOUR] = hour_next;
            if (day_wrap) begin
                nxt_regs[`RTCAM_OFF_WDAY] = (t_wday[2:0] == `RTCAM_MAX_WDAY) ? 8'h01
                                                                           : t_wday + 8'h01;
                nxt_regs[`RTCAM_OFF_MDAY] = (t_mday[5:0] == `RTCAM_MAX_MDAY) ? 8'h01
                                                                           : bcd_inc(t_mday);
            end
        end
        if (wr.en && wr.addr != `RTCAM_OFF_STAT) nxt_regs[wr.addr] = wr.data & wr_mask(wr.addr);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) regs_ff[i] <= `RTCAM_RST_ZERO;
            regs_ff[`RTCAM_OFF_WDAY] <= `RTCAM_RST_ONE;
            regs_ff[`RTCAM_OFF_MDAY] <= `RTCAM_RST_ONE;
            regs_ff[`RTCAM_OFF_CTRL] <= `RTCAM_RST_CTRL;
        end else begin
            for (int i = 0; i < 16; i++) regs_ff[i] <= nxt_regs[i];
        end
    end

    // alarm comparators, evaluated the cycle after each update
    always_ff @(posedge core_clk) begin
        if (!rst_n) eval_ff <= 1'b0;
        else eval_ff <= tick_core;
    end

    wire [7:0] a1_sec = regs_ff[`RTCAM_OFF_A1_SEC];
    wire [7:0] a1_min = regs_ff[`RTCAM_OFF_A1_MIN];
    wire [7:0] a1_hour = regs_ff[`RTCAM_OFF_A1_HOUR];
    wire [7:0] a1_day = regs_ff[`RTCAM_OFF_A1_DAY];
    wire [7:0] a2_min = regs_ff[`RTCAM_OFF_A2_MIN];
    wire [7:0] a2_hour = regs_ff[`RTCAM_OFF_A2_HOUR];
    wire [7:0] a2_day = regs_ff[`RTCAM_OFF_A2_DAY];

    wire alarm_one_sec_mask = a1_sec[`RTCAM_MASK_BIT];
    wire alarm_one_min_mask = a1_min[`RTCAM_MASK_BIT];
    wire alarm_one_hour_mask = a1_hour[`RTCAM_MASK_BIT];
    wire alarm_one_day_mask = a1_day[`RTCAM_MASK_BIT];
    wire alarm_two_min_mask = a2_min[`RTCAM_MASK_BIT];
    wire alarm_two_hour_mask = a2_hour[`RTCAM_MASK_BIT];
    wire alarm_two_day_mask = a2_day[`RTCAM_MASK_BIT];

    // hour compare includes the format bit, so mixed formats never match
    wire a1_sec_eq = a1_sec[6:0] == t_sec[6:0];
    wire a1_min_eq = a1_min[6:0] == t_min[6:0];
    wire a1_hour_eq = a1_hour[6:0] == t_hour[6:0];
    wire a1_day_eq = a1_day[`RTCAM_DAYSEL_BIT] ? (a1_day[2:0] == t_wday[2:0])
                                              : (a1_day[5:0] == t_mday[5:0]);
    wire a2_min_eq = a2_min[6:0] == t_min[6:0];
    wire a2_hour_eq = a2_hour[6:0] == t_hour[6:0];
    wire a2_day_eq = a2_day[`RTCAM_DAYSEL_BIT] ? (a2_day[2:0] == t_wday[2:0])
                                              : (a2_day[5:0] == t_mday[5:0]);

    wire [3:0] a1_masks = {alarm_one_day_mask, alarm_one_hour_mask,
                           alarm_one_min_mask, alarm_one_sec_mask};
    wire [2:0] a2_masks = {alarm_two_day_mask, alarm_two_hour_mask, alarm_two_min_mask};
    wire a1_valid = a1_masks inside {4'hf, 4'he, 4'hc, 4'h8, 4'h0};
    wire a2_valid = a2_masks inside {3'h7, 3'h6, 3'h4, 3'h0};
    wire a1_hit = a1_valid & (alarm_one_sec_mask | a1_sec_eq) & (alarm_one_min_mask | a1_min_eq)
                & (alarm_one_hour_mask | a1_hour_eq) & (alarm_one_day_mask | a1_day_eq);
    wire a2_hit = a2_valid & (t_sec[6:0] == 7'h00) & (alarm_two_min_mask | a2_min_eq)
                & (alarm_two_hour_mask | a2_hour_eq) & (alarm_two_day_mask | a2_day_eq);

    // status flags: set wins over a software clear
    wire stat_wr = wr.en & (wr.addr == `RTCAM_OFF_STAT);
    wire keep_a1 = ~stat_wr | wr.data[`RTCAM_STAT_A1F_BIT];
    wire keep_a2 = ~stat_wr | wr.data[`RTCAM_STAT_A2F_BIT];
    wire keep_osf = ~stat_wr | wr.data[`RTCAM_STAT_OSF_BIT];
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarm_one_flag_ff <= 1'b0;
            alarm_two_flag_ff <= 1'b0;
            osc_stopped_flag_ff <= 1'b1;
        end else begin
            alarm_one_flag_ff <= (eval_ff & a1_hit) | (alarm_one_flag_ff & keep_a1);
            alarm_two_flag_ff <= (eval_ff & a2_hit) | (alarm_two_flag_ff & keep_a2);
            osc_stopped_flag_ff <= osc_stopped_flag_ff & keep_osf;
        end
    end
    wire [7:0] stat_rd = {osc_stopped_flag_ff, 5'h00, alarm_two_flag_ff, alarm_one_flag_ff};

    // interrupt mapping, open-drain active low
    wire a1_irq = alarm_one_flag_ff & alarm_one_irq_enable;
    wire a2_irq = alarm_two_flag_ff & alarm_two_irq_enable;
    assign irq_out_primary_o = 1'b0;
    assign wave_or_irq_out_secondary_o = 1'b0;
    assign irq_out_primary_oe = a1_irq | (a2_irq & ~irq_mapping_select);
    assign wave_or_irq_out_secondary_oe = a2_irq & irq_mapping_select;

    // serial bus slave
    rtcam_state_type state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bitcnt_ff, ptr_ff;
    logic first_ff, rw_ff, nack_ff, sda_oe_ff;
    wire addr_hit = shift_ff[7:1] == `RTCAM_SLAVE_ADDR;
    wire byte_done = scl_fall & (bitcnt_ff == `RTCAM_BITS_PER_BYTE);
    wire [7:0] rd_data = (ptr_ff == `RTCAM_OFF_STAT) ? stat_rd : regs_ff[ptr_ff];
    assign wr.en = (state_ff == ST_RX) & byte_done & ~first_ff;
    assign wr.addr = ptr_ff;
    assign wr.data = shift_ff;
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_ff;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bitcnt_ff <= 4'h0;
            ptr_ff <= 4'h0;
            first_ff <= 1'b0;
            rw_ff <= 1'b0;
            nack_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (bus_start) begin
            state_ff <= ST_ADDR;
            bitcnt_ff <= 4'h0;
            first_ff <= 1'b1;
            sda_oe_ff <= 1'b0;
        end else if (bus_stop) begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                    end else if (byte_done) begin
                        if (state_ff == ST_ADDR) begin
                            state_ff <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                            sda_oe_ff <= addr_hit;
                            rw_ff <= shift_ff[0];
                        end else begin
                            state_ff <= ST_RX_ACK;
                            sda_oe_ff <= 1'b1;
                            first_ff <= 1'b0;
                            ptr_ff <= first_ff ? shift_ff[3:0] : ptr_ff + 4'h1;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (scl_fall) begin
                        bitcnt_ff <= 4'h0;
                        if (state_ff == ST_ADDR_ACK && rw_ff) begin
                            state_ff <= ST_TX;
                            shift_ff <= rd_data;
                            sda_oe_ff <= ~rd_data[7];
                            ptr_ff <= ptr_ff + 4'h1;
                        end else begin
                            state_ff <= ST_RX;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bitcnt_ff == 4'h7) begin
                            state_ff <= ST_TX_ACK;
                            sda_oe_ff <= 1'b0;
                        end else begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            sda_oe_ff <= ~shift_ff[6];
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) nack_ff <= sda_s;
                    else if (scl_fall) begin
                        bitcnt_ff <= 4'h0;
                        state_ff <= nack_ff ? ST_IDLE : ST_TX;
                        if (!nack_ff) begin
                            shift_ff <= rd_data;
                            sda_oe_ff <= ~rd_data[7];
                            ptr_ff <= ptr_ff + 4'h1;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    flag_one_set_a: assert property (eval_ff && a1_hit |=> alarm_one_flag_ff)
        else $error("alarm one match did not set its flag");
    flag_sticky_a: assert property (alarm_one_flag_ff && !stat_wr |=> alarm_one_flag_ff)
        else $error("alarm one flag dropped without a clear");
    eval_on_tick_a: assert property ($rose(alarm_two_flag_ff) |-> $past(eval_ff))
        else $error("alarm two flag rose outside an update");
    mask_ignored_a: assert property (eval_ff && !a1_valid && !alarm_one_flag_ff
                                     |=> !alarm_one_flag_ff)
        else $error("invalid alarm one mask still fired");
    minute_rate_a: assert property (eval_ff && a2_masks == 3'h7 && t_sec == 8'h00
                                    |=> alarm_two_flag_ff)
        else $error("alarm two missed the top of the minute");
    irq_drive_a: assert property (alarm_one_flag_ff && alarm_one_irq_enable
                                  |-> irq_out_primary_oe && !irq_out_primary_o)
        else $error("enabled alarm one flag did not pull the interrupt");
    irq_map_a: assert property (a2_irq && !a1_irq |-> irq_out_primary_oe
                                != wave_or_irq_out_secondary_oe)
        else $error("alarm two interrupt mapping wrong");
    irq_release_a: assert property (!a1_irq && !a2_irq |-> !irq_out_primary_oe
                                    && !wave_or_irq_out_secondary_oe)
        else $error("interrupt pin driven with no enabled flag");
    addr_ack_a: assert property ($rose(state_ff == ST_ADDR_ACK) |-> sda_oe_ff
                                 && $past(shift_ff[7:1]) == `RTCAM_SLAVE_ADDR)
        else $error("acknowledged a foreign address");
    tx_low_change_a: assert property (state_ff == ST_TX && $changed(sda_oe_ff)
                                      |-> !scl_s)
        else $error("data changed while clock high");

    alarm_one_c: cover property (eval_ff && a1_hit && a1_masks == 4'h0);
    alarm_two_c: cover property (eval_ff && a2_hit && a2_masks == 3'h0);
    bus_write_c: cover property (wr.en && wr.addr == `RTCAM_OFF_CTRL);
    bus_read_c: cover property (state_ff == ST_TX_ACK ##1 state_ff == ST_TX);

endmodule : rtcam_alarm_core

// >>> sim/rtcam_bus_master.sv
`timescale 1ns/1ps
// two-wire bus master model; a pull output is high while it holds its line low
module rtcam_bus_master (
    // clock and resolved lines
    input wire logic clk,
    input wire logic scl_line,
    input wire logic sda_line,
    // open-drain pulls
    output logic scl_pull,
    output logic sda_pull
);
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    task automatic quarter();
        repeat (5) @(posedge clk);
        #1;
    endtask : quarter
    task automatic start_cond();
        sda_pull = 1'b0;
        quarter();
        scl_pull = 1'b0;
        quarter();
        sda_pull = 1'b1;
        quarter();
        scl_pull = 1'b1;
        quarter();
    endtask : start_cond
    task automatic stop_cond();
        sda_pull = 1'b1;
        quarter();
        scl_pull = 1'b0;
        quarter();
        sda_pull = 1'b0;
        quarter();
    endtask : stop_cond
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull = ~b;
        quarter();
        scl_pull = 1'b0;
        quarter();
        r = sda_line;
        quarter();
        scl_pull = 1'b1;
        quarter();
    endtask : xfer_bit
    task automatic xfer_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
        output logic ack);
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], r[i]);
        xfer_bit(ack_in, ack);
    endtask : xfer_byte
endmodule : rtcam_bus_master

// >>> sim/test_rtcam_alarm_core.sv
`timescale 1ns/1ps
module test_rtcam_alarm_core;
    import rtcam_pkg::*;
    typedef struct packed {
        logic [7:0] tsec, a1s, a1m, a1h, a1d, a2m, a2h, a2d, ctrl;
        logic [1:0] flags;
        logic pri, sec;
    } rtcam_row_type;
    logic core_clk = 1'b0;
    logic time_clk = 1'b0;
    logic rst_n = 1'b0;
    logic time_rst_n = 1'b0;
    logic time_tick = 1'b0;
    logic scl_pull, sda_pull, sda_o, sda_oe, pri_o, pri_oe, sec_o, sec_oe, ack;
    logic [7:0] rd;
    logic [7:0] q[$];
    int num_errors = 0;
    int check_count = 0;
    wire scl_line = ~scl_pull;
    wire sda_line = ~(sda_pull | sda_oe);
    rtcam_lines_type bus_i;
    assign bus_i = {scl_line, sda_line};
    rtcam_row_type rows[9] = '{
        '{8'h29, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h07, 2'b01, 1'b1, 1'b0},
        '{8'h29, 8'h30, 8'h80, 8'h80, 8'h80, 8'h15, 8'h80, 8'h80, 8'h06, 2'b01, 1'b0, 1'b0},
        '{8'h59, 8'h00, 8'h16, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h07, 2'b11, 1'b1, 1'b1},
        '{8'h59, 8'h00, 8'h16, 8'h10, 8'h80, 8'h16, 8'h10, 8'h80, 8'h03, 2'b11, 1'b1, 1'b0},
        '{8'h59, 8'h00, 8'h16, 8'h10, 8'h21, 8'h16, 8'h10, 8'h43, 8'h02, 2'b11, 1'b1, 1'b0},
        '{8'h59, 8'h00, 8'h16, 8'h10, 8'h03, 8'h16, 8'h10, 8'h61, 8'h07, 2'b00, 1'b0, 1'b0},
        '{8'h59, 8'h00, 8'h16, 8'h50, 8'h80, 8'h16, 8'h50, 8'h80, 8'h07, 2'b00, 1'b0, 1'b0},
        '{8'h59, 8'h00, 8'h16, 8'h11, 8'h80, 8'h17, 8'h80, 8'h80, 8'h07, 2'b00, 1'b0, 1'b0},
        '{8'h59, 8'h80, 8'h16, 8'h80, 8'h80, 8'h80, 8'h10, 8'h80, 8'h07, 2'b00, 1'b0, 1'b0}};
    always #12.5 core_clk = ~core_clk;
    always #24 time_clk = ~time_clk;
    rtcam_alarm_core i_rtcam_alarm_core (.core_clk(core_clk), .rst_n(rst_n), .time_clk(time_clk),
        .time_rst_n(time_rst_n), .time_tick(time_tick), .bus_i(bus_i), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq_out_primary_o(pri_o), .irq_out_primary_oe(pri_oe),
        .wave_or_irq_out_secondary_o(sec_o), .wave_or_irq_out_secondary_oe(sec_oe));
    rtcam_bus_master i_rtcam_bus_master (.clk(core_clk), .scl_line(scl_line),
        .sda_line(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp, input string what);
        check8({7'h00, got}, {7'h00, exp}, what);
    endtask : check1
    task automatic send(input logic [7:0] b);
        i_rtcam_bus_master.xfer_byte(b, 1'b1, rd, ack);
        check1(ack, 1'b0, "ack");
    endtask : send
    task automatic wr_regs(input logic [3:0] ptr);
        i_rtcam_bus_master.start_cond();
        send(8'hd0);
        send({4'h0, ptr});
        foreach (q[i]) send(q[i]);
        i_rtcam_bus_master.stop_cond();
    endtask : wr_regs
    task automatic rd_reg(input logic [3:0] ptr, output logic [7:0] v);
        i_rtcam_bus_master.start_cond();
        send(8'hd0);
        send({4'h0, ptr});
        i_rtcam_bus_master.start_cond();
        send(8'hd1);
        i_rtcam_bus_master.xfer_byte(8'hff, 1'b1, v, ack);
        i_rtcam_bus_master.stop_cond();
    endtask : rd_reg
    task automatic tick();
        @(posedge time_clk);
        #1 time_tick = 1'b1;
        @(posedge time_clk);
        #1 time_tick = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic do_reset();
        rst_n = 1'b0;
        time_rst_n = 1'b0;
        repeat (2) @(posedge time_clk);
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        time_rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : do_reset
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (95000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            q = {rows[i].tsec, 8'h15, 8'h10, 8'h03, 8'h21, 8'h00, 8'h00, rows[i].a1s, rows[i].a1m,
                rows[i].a1h, rows[i].a1d, rows[i].a2m, rows[i].a2h, rows[i].a2d, rows[i].ctrl, 8'h00};
            wr_regs(4'h0);
            rd_reg(4'hf, rd);
            check8(rd, 8'h00, "flags before tick");
            tick();
            rd_reg(4'hf, rd);
            check8(rd, {6'h00, rows[i].flags}, "flags");
            check1(pri_oe, rows[i].pri, "primary irq");
            check1(sec_oe, rows[i].sec, "secondary irq");
            $display("row %0d done", i);
        end
        q = {8'h80, 8'h80, 8'h80, 8'h80};
        wr_regs(4'h7);
        tick();
        q = {8'h45};
        wr_regs(4'h7);
        tick();
        rd_reg(4'hf, rd);
        check8(rd, 8'h01, "sticky flag");
        check1(pri_oe, 1'b1, "held irq");
        q = {8'h02};
        wr_regs(4'hf);
        rd_reg(4'hf, rd);
        check8(rd, 8'h00, "cleared flag");
        check1(pri_oe, 1'b0, "released irq");
        $display("sticky flag test done");
        i_rtcam_bus_master.start_cond();
        i_rtcam_bus_master.xfer_byte(8'hd2, 1'b1, rd, ack);
        check1(ack, 1'b1, "foreign address");
        i_rtcam_bus_master.stop_cond();
        check1(sda_line, 1'b1, "idle data");
        check1(scl_line, 1'b1, "idle clock");
        $display("address test done");
        q = {8'h59, 8'h59, 8'h71, 8'h07};
        wr_regs(4'h0);
        tick();
        rd_reg(4'h2, rd);
        check8(rd, 8'h52, "pm eleven to am twelve");
        rd_reg(4'h3, rd);
        check8(rd, 8'h01, "weekday wrap");
        q = {8'h87};
        wr_regs(4'he);
        tick();
        rd_reg(4'h0, rd);
        check8(rd, 8'h00, "count stopped");
        $display("hour format test done");
        do_reset();
        check1(sda_oe, 1'b0, "reset data pull");
        check1(pri_oe, 1'b0, "reset primary");
        check8({5'h00, sda_o, pri_o, sec_o}, 8'h00, "pin drive levels");
        rd_reg(4'hf, rd);
        check8(rd, 8'h80, "reset status");
        rd_reg(4'he, rd);
        check8(rd, 8'h1c, "reset control");
        rd_reg(4'h3, rd);
        check8(rd, 8'h01, "reset weekday");
        $display("reset test done");
        final_report();
    end
endmodule : test_rtcam_alarm_core
